// File: logic/sws_defs.svh
`ifndef SWS_DEFS_SVH
`define SWS_DEFS_SVH

// Opcodes, sent most significant bit first.
`define SWS_OP_LATCH_SET 8'h06
`define SWS_OP_LATCH_CLEAR 8'h04
`define SWS_OP_STATUS_READ 8'h05
`define SWS_OP_STATUS_WRITE 8'h01
`define SWS_OP_FLAG_SET 8'h00

// Bit positions inside the status byte.
`define SWS_BIT_GPE 7
`define SWS_BIT_FLAG 6
`define SWS_BIT_WD_HI 5
`define SWS_BIT_WD_LO 4
`define SWS_BIT_AG_HI 3
`define SWS_BIT_AG_LO 2
`define SWS_BIT_LATCH 1
`define SWS_BIT_BUSY 0

// Values the nonvolatile fields hold after the initial reset.
`define SWS_RST_GPE 1'b0
`define SWS_RST_WD 2'h0
`define SWS_RST_AG 2'h0

// Watchdog period codes and periods in milliseconds (1400, 600, 200).
`define SWS_WD_LONG 2'h0
`define SWS_WD_MID 2'h1
`define SWS_WD_SHORT 2'h2
`define SWS_WD_OFF 2'h3
`define SWS_WD_LONG_MS 11'h578
`define SWS_WD_MID_MS 11'h258
`define SWS_WD_SHORT_MS 11'h0c8

// Reset hold after low supply or a watchdog bite, in milliseconds (200).
`define SWS_HOLD_MS 8'hc8

// Core clock rate in hertz and the timebase tick period in microseconds.
`define SWS_CORE_HZ 10000000
`define SWS_TICK_US 1000

// Length of a nonvolatile write cycle in core clock cycles.
`define SWS_NV_WRITE_CYCLES 1000

// Bit counts that close an opcode-only or an opcode-plus-data frame.
`define SWS_BITS_OP 5'h08
`define SWS_BITS_OPDATA 5'h10

`endif

// File: logic/sws_pkg.sv
package sws_pkg;

  // How the last frame ended, as seen at its final clock edge.
  typedef enum logic [1:0] {
    SWS_LEN_NONE = 2'h0,
    SWS_LEN_OP = 2'h1,
    SWS_LEN_OPDATA = 2'h3,
    SWS_LEN_ODD = 2'h2
  } sws_len_type;

  // Nonvolatile write engine, Gray coded.
  typedef enum logic [1:0] {
    SWS_NV_IDLE = 2'h0,
    SWS_NV_BUSY = 2'h1
  } sws_nv_state_type;

  // Link state cleared by every deselect.
  typedef struct packed {
    logic [4:0] bits;
    logic long_frame;
  } sws_count_type;

  // Link state that must survive the deselect so the core can read it.
  typedef struct packed {
    logic [7:0] shift;
    logic [7:0] cmd;
    logic [7:0] data;
    sws_len_type len;
    logic frame_tog;
  } sws_link_type;

  // Serial output stage, updated on falling clock edges.
  typedef struct packed {
    logic so;
    logic so_oe;
  } sws_out_type;

  // Everything that runs on the core clock.
  typedef struct packed {
    logic [1:0] cs_sync;
    logic cs_prev;
    logic [1:0] wg_sync;
    logic [1:0] low_sync;
    logic [1:0] tog_sync;
    logic tog_seen;
    logic armed;
    logic gpe;
    logic flag;
    logic [1:0] wd;
    logic [1:0] ag;
    logic latch;
    sws_nv_state_type nv_state;
    logic [15:0] nv_cnt;
    logic [7:0] nv_pending;
    logic [7:0] status_pub;
    logic [13:0] tick_cnt;
    logic tick;
    logic [10:0] wd_ms;
    logic [7:0] hold_ms;
    logic rst_drive;
    logic rst_oe;
  } sws_core_type;

endpackage

// File: logic/sws_supervisor.sv
`timescale 1ns/10ps
`include "sws_defs.svh"

// Notes on behaviour
// - Deselected while select is high; serial output released.
// - No command acts until a select falling edge has been seen after power-up.
// - Guard pin low with guard enable set refuses status writes only.
// - Guard pin high lets every function work, status writes included.
// - A status write already running finishes even if the guard pin falls.
// - Guard enable clear makes the guard pin irrelevant.
// - Reset asserted on low supply, held until supply is good for 200 ms.
// - Enabled watchdog asserts reset when select shows no falling edge in time.
// - Each select falling edge restarts the watchdog count.
// - Reset pin is open drain, active level chosen per variant.
// - Eight-bit instruction register shifted in on rising serial clock.
// - All bytes travel most significant bit first.
// - First bit is taken at the first rising edge after select falls.
// - Serial output changes on falling serial clock edges.
// - Serial logic is static; the clock may pause anywhere.
// - Writes need the write latch; set and clear opcodes control it.
// - Write latch clears at power-up and after each completed write.
// - Status read works at any time, even during a write cycle.
// - Status byte: guard enable, flag, two period, two guard, latch, busy.
// - Watchdog period picked from three presets, kept in nonvolatile bits.
// - Serial clock may idle low or high; sampling is always rising.
// - Period codes: 00 1.4 s, 01 600 ms, 10 200 ms, 11 off.
// - Opcodes: set latch 06, clear latch 04, status read 05, status write 01.
// - Busy bit reads 1 during a nonvolatile write, 0 otherwise.
module sws_supervisor #(
  parameter int TICK_CYCLES = `SWS_TICK_US * (`SWS_CORE_HZ / 1000000),
  parameter int NV_WRITE_CYCLES = `SWS_NV_WRITE_CYCLES,
  parameter bit RESET_ACTIVE_HIGH = 1'b0
) (
  // Core clock and reset.
  input wire logic core_clk,
  input wire logic rst_n,
  // Serial link from the master.
  input wire logic sck,
  input wire logic cs_n,
  input wire logic si,
  output logic so,
  output logic so_oe,
  // Supervisory inputs.
  input wire logic write_guard_n,
  input wire logic supply_low,
  // Open-drain reset pin.
  output logic reset_level,
  output logic reset_oe
);
  import sws_pkg::*;

  sws_count_type cnt;
  sws_count_type next_cnt;
  sws_link_type lk;
  sws_link_type next_lk;
  sws_out_type ot;
  sws_out_type next_ot;
  sws_core_type st;
  sws_core_type next_st;
  logic cs_fall;
  logic cs_rise;
  logic frame_new;
  logic guard_blocks;
  logic [7:0] shift_in;
  logic [4:0] bits_inc;

  // Status byte assembled from the live fields at their documented positions.
  function automatic logic [7:0] status_word(input sws_core_type s);
    logic [7:0] w;
    w = 8'h00;
    w[`SWS_BIT_GPE] = s.gpe;
    w[`SWS_BIT_FLAG] = s.flag;
    w[`SWS_BIT_WD_HI] = s.wd[1];
    w[`SWS_BIT_WD_LO] = s.wd[0];
    w[`SWS_BIT_AG_HI] = s.ag[1];
    w[`SWS_BIT_AG_LO] = s.ag[0];
    w[`SWS_BIT_LATCH] = s.latch;
    w[`SWS_BIT_BUSY] = (s.nv_state == SWS_NV_BUSY);
    return w;
  endfunction

  // Watchdog limit in milliseconds for a period code.
  function automatic logic [10:0] wd_limit(input logic [1:0] code);
    logic [10:0] l;
    l = `SWS_WD_LONG_MS;
    case (code)
      `SWS_WD_MID: l = `SWS_WD_MID_MS;
      `SWS_WD_SHORT: l = `SWS_WD_SHORT_MS;
      default: l = `SWS_WD_LONG_MS;
    endcase
    return l;
  endfunction

  // Link side: shift, count and frame result, all on rising serial clock.
  always_comb begin
    next_cnt = cnt;
    next_lk = lk;
    shift_in = {lk.shift[6:0], si};
    bits_inc = 5'(cnt.bits + 5'h01);
    next_lk.shift = shift_in;
    next_cnt.bits = bits_inc;
    next_cnt.long_frame = cnt.long_frame | (cnt.bits == `SWS_BITS_OPDATA);
    // A new frame is flagged once, at its first bit, for the core to spot.
    if (cnt.bits == 5'h00 && !cnt.long_frame) begin
      next_lk.frame_tog = ~lk.frame_tog;
    end
    if (bits_inc == `SWS_BITS_OP && !cnt.long_frame) begin
      next_lk.cmd = shift_in;
      next_lk.len = SWS_LEN_OP;
    end else if (bits_inc == `SWS_BITS_OPDATA && !cnt.long_frame) begin
      next_lk.data = shift_in;
      next_lk.len = SWS_LEN_OPDATA;
    end else begin
      next_lk.len = SWS_LEN_ODD;
    end
    // A master switching clock idle level makes edges while deselected; they must not count.
    if (cs_n) begin
      next_lk = lk;
    end
  end

  // The bit count restarts on every deselect, so a paused clock resumes cleanly.
  always_ff @(posedge sck or posedge cs_n) begin
    if (cs_n) begin
      cnt <= '0;
    end else begin
      cnt <= next_cnt;
    end
  end

  // Frame results survive the deselect; the core reads them after it.
  always_ff @(posedge sck or negedge rst_n) begin
    if (!rst_n) begin
      lk <= '0;
    end else begin
      lk <= next_lk;
    end
  end

  // Output stage: status bits go out after the opcode, most significant first.
  always_comb begin
    next_ot.so_oe = 1'b1;
    next_ot.so = 1'b0;
    if ((cnt.bits >= `SWS_BITS_OP || cnt.long_frame) && lk.cmd == `SWS_OP_STATUS_READ) begin
      next_ot.so = st.status_pub[3'(~cnt.bits[2:0])];
    end
  end

  // The published status only moves while deselected, so it is steady here.
  always_ff @(negedge sck or posedge cs_n) begin
    if (cs_n) begin
      ot <= '0;
    end else begin
      ot <= next_ot;
    end
  end

  assign so = ot.so;
  assign so_oe = ot.so_oe;

  // Core side: synchronisers, command execution, write engine and watchdog.
  always_comb begin
    next_st = st;
    next_st.cs_sync = {st.cs_sync[0], cs_n};
    next_st.cs_prev = st.cs_sync[1];
    next_st.wg_sync = {st.wg_sync[0], write_guard_n};
    next_st.low_sync = {st.low_sync[0], supply_low};
    next_st.tog_sync = {st.tog_sync[0], lk.frame_tog};
    cs_fall = st.cs_prev & ~st.cs_sync[1];
    cs_rise = ~st.cs_prev & st.cs_sync[1];
    frame_new = st.tog_sync[1] ^ st.tog_seen;
    guard_blocks = st.gpe & ~st.wg_sync[1];
    if (cs_fall) begin
      next_st.armed = 1'b1;
    end
    // Frames are acted on at their end, which also ignores opcodes cut short.
    if (cs_rise) begin
      next_st.tog_seen = st.tog_sync[1];
      if (st.armed && frame_new && st.nv_state == SWS_NV_IDLE) begin
        case (lk.len)
          SWS_LEN_OP: begin
            case (lk.cmd)
              `SWS_OP_LATCH_SET: next_st.latch = 1'b1;
              `SWS_OP_LATCH_CLEAR: begin
                next_st.latch = 1'b0;
                next_st.flag = 1'b0;
              end
              `SWS_OP_FLAG_SET: next_st.flag = 1'b1;
              default: begin
              end
            endcase
          end
          SWS_LEN_OPDATA: begin
            if (lk.cmd == `SWS_OP_STATUS_WRITE && st.latch && !guard_blocks) begin
              next_st.nv_state = SWS_NV_BUSY;
              next_st.nv_cnt = 16'h0000;
              next_st.nv_pending = lk.data;
            end
          end
          default: begin
          end
        endcase
      end
    end
    // The guard pin is only looked at when a write starts, never mid-cycle.
    case (st.nv_state)
      SWS_NV_BUSY: begin
        if (st.nv_cnt == 16'(NV_WRITE_CYCLES - 1)) begin
          next_st.nv_state = SWS_NV_IDLE;
          next_st.nv_cnt = 16'h0000;
          next_st.latch = 1'b0;
          next_st.gpe = st.nv_pending[`SWS_BIT_GPE];
          next_st.wd = {st.nv_pending[`SWS_BIT_WD_HI], st.nv_pending[`SWS_BIT_WD_LO]};
          next_st.ag = {st.nv_pending[`SWS_BIT_AG_HI], st.nv_pending[`SWS_BIT_AG_LO]};
        end else begin
          next_st.nv_cnt = 16'(st.nv_cnt + 16'h0001);
        end
      end
      SWS_NV_IDLE: begin
      end
      default: next_st.nv_state = SWS_NV_IDLE;
    endcase
    if (st.cs_sync[1]) begin
      next_st.status_pub = status_word(st);
    end
    // Free-running millisecond tick, independent of the serial clock.
    if (st.tick_cnt == 14'(TICK_CYCLES - 1)) begin
      next_st.tick_cnt = 14'h0000;
      next_st.tick = 1'b1;
    end else begin
      next_st.tick_cnt = 14'(st.tick_cnt + 14'h0001);
      next_st.tick = 1'b0;
    end
    if (st.tick && st.hold_ms != 8'h00) begin
      next_st.hold_ms = 8'(st.hold_ms - 8'h01);
    end
    // Only falling select edges restart the count, so stuck high or low both bite.
    if (cs_fall || st.wd == `SWS_WD_OFF || st.hold_ms != 8'h00) begin
      next_st.wd_ms = 11'h000;
    end else if (st.tick) begin
      if (st.wd_ms == wd_limit(st.wd)) begin
        next_st.wd_ms = 11'h000;
        next_st.hold_ms = `SWS_HOLD_MS;
      end else begin
        next_st.wd_ms = 11'(st.wd_ms + 11'h001);
      end
    end
    if (st.low_sync[1]) begin
      next_st.hold_ms = `SWS_HOLD_MS;
    end
    next_st.rst_oe = (next_st.hold_ms != 8'h00);
    next_st.rst_drive = RESET_ACTIVE_HIGH;
  end

  // Reset starts the hold so the reset pin is active from power-up.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      st <= '0;
      // The select sampler starts low, so a select held low through reset is no edge.
      st.wg_sync <= 2'h3;
      st.gpe <= `SWS_RST_GPE;
      st.wd <= `SWS_RST_WD;
      st.ag <= `SWS_RST_AG;
      st.latch <= 1'b0;
      st.hold_ms <= `SWS_HOLD_MS;
      st.rst_oe <= 1'b1;
      st.rst_drive <= RESET_ACTIVE_HIGH;
    end else begin
      st <= next_st;
    end
  end

  assign reset_level = st.rst_drive;
  assign reset_oe = st.rst_oe;

  // Checks on the core clock.
  chk_so_hiz_deselect: assert property (@(posedge core_clk) disable iff (!rst_n)
    cs_n |-> !so_oe)
    else $error("serial output driven while deselected");

  chk_arm_before_use: assert property (@(posedge core_clk) disable iff (!rst_n)
    !st.armed |-> st.nv_state == SWS_NV_IDLE && !st.latch)
    else $error("state changed before first select falling edge");

  chk_guard_refuse: assert property (@(posedge core_clk) disable iff (!rst_n)
    $rose(st.nv_state == SWS_NV_BUSY) |-> !($past(st.gpe) && !$past(st.wg_sync[1])))
    else $error("status write started while guarded");

  chk_write_runs_out: assert property (@(posedge core_clk) disable iff (!rst_n)
    st.nv_state == SWS_NV_BUSY && st.nv_cnt != 16'(NV_WRITE_CYCLES - 1)
      |=> st.nv_state == SWS_NV_BUSY)
    else $error("status write cycle cut short");

  chk_latch_needed: assert property (@(posedge core_clk) disable iff (!rst_n)
    $rose(st.nv_state == SWS_NV_BUSY) |-> $past(st.latch))
    else $error("status write started without latch");

  chk_latch_auto_clear: assert property (@(posedge core_clk) disable iff (!rst_n)
    $fell(st.nv_state == SWS_NV_BUSY) |-> !st.latch && st.nv_cnt == 16'h0000)
    else $error("latch not cleared after write");

  chk_supply_reset: assert property (@(posedge core_clk) disable iff (!rst_n)
    st.low_sync[1] |=> st.rst_oe && st.hold_ms == `SWS_HOLD_MS)
    else $error("low supply did not hold reset");

  chk_hold_release: assert property (@(posedge core_clk) disable iff (!rst_n)
    $fell(st.rst_oe) |-> $past(st.hold_ms) == 8'h01 && $past(st.tick) && !$past(st.low_sync[1]))
    else $error("reset released before hold ran out");

  chk_wd_restart: assert property (@(posedge core_clk) disable iff (!rst_n)
    st.cs_prev && !st.cs_sync[1] |=> st.wd_ms == 11'h000)
    else $error("select falling edge did not restart watchdog");

  chk_wd_bite: assert property (@(posedge core_clk) disable iff (!rst_n)
    st.tick && st.wd != `SWS_WD_OFF && st.hold_ms == 8'h00 && !st.low_sync[1]
      && !(st.cs_prev && !st.cs_sync[1]) && st.wd_ms == wd_limit(st.wd)
      |=> st.rst_oe ##1 st.rst_oe)
    else $error("watchdog timeout did not assert reset");

  chk_reset_pin_level: assert property (@(posedge core_clk) disable iff (!rst_n)
    st.rst_oe |-> reset_level == RESET_ACTIVE_HIGH)
    else $error("reset pin driven to wrong level");

  chk_odd_frame_refused: assert property (@(posedge core_clk) disable iff (!rst_n)
    cs_rise && lk.len == SWS_LEN_ODD && st.nv_state == SWS_NV_IDLE
      |=> $stable(st.latch) && $stable(st.flag) && st.nv_state == SWS_NV_IDLE)
    else $error("frame of wrong length was acted on");

  chk_busy_refuses: assert property (@(posedge core_clk) disable iff (!rst_n)
    st.nv_state == SWS_NV_BUSY && st.nv_cnt != 16'(NV_WRITE_CYCLES - 1)
      |=> $stable(st.latch) && $stable(st.flag))
    else $error("command acted on during a write cycle");

  chk_write_accept: assert property (@(posedge core_clk) disable iff (!rst_n)
    cs_rise && st.armed && frame_new && st.nv_state == SWS_NV_IDLE && st.latch
      && lk.len == SWS_LEN_OPDATA && lk.cmd == `SWS_OP_STATUS_WRITE
      && (!st.gpe || st.wg_sync[1]) |=> st.nv_state == SWS_NV_BUSY)
    else $error("permitted status write was refused");

  chk_latch_set_cmd: assert property (@(posedge core_clk) disable iff (!rst_n)
    cs_rise && st.armed && frame_new && st.nv_state == SWS_NV_IDLE
      && lk.len == SWS_LEN_OP && lk.cmd == `SWS_OP_LATCH_SET |=> st.latch)
    else $error("latch set opcode did not set the latch");

  chk_status_frozen: assert property (@(posedge core_clk) disable iff (!rst_n)
    !st.cs_sync[1] |=> $stable(st.status_pub))
    else $error("published status moved during a frame");

  chk_idle_not_busy: assert property (@(posedge core_clk) disable iff (!rst_n)
    st.nv_state == SWS_NV_IDLE && st.cs_sync[1] |=> !st.status_pub[`SWS_BIT_BUSY])
    else $error("busy bit published while no write runs");

  chk_wd_off_quiet: assert property (@(posedge core_clk) disable iff (!rst_n)
    st.wd == `SWS_WD_OFF |=> st.wd_ms == 11'h000)
    else $error("disabled watchdog kept counting");

  cov_status_write: cover property (@(posedge core_clk) disable iff (!rst_n)
    $fell(st.nv_state == SWS_NV_BUSY));

  cov_watchdog_bite: cover property (@(posedge core_clk) disable iff (!rst_n)
    st.tick && st.wd_ms == wd_limit(st.wd) && st.wd != `SWS_WD_OFF ##1 st.rst_oe);

  cov_status_read: cover property (@(posedge core_clk) disable iff (!rst_n)
    !st.cs_prev && st.cs_sync[1] && lk.cmd == `SWS_OP_STATUS_READ);

  cov_latch_set: cover property (@(posedge core_clk) disable iff (!rst_n)
    $rose(st.latch));

  cov_guard_refused: cover property (@(posedge core_clk) disable iff (!rst_n)
    cs_rise && guard_blocks && st.latch && lk.cmd == `SWS_OP_STATUS_WRITE);

endmodule

// File: sim/sws_master_model.sv
`timescale 1ns/10ps

// Serial bus master; its clock stands still between frames.
module sws_master_model (
  // Serial link.
  output logic sck,
  output logic cs_n,
  output logic si,
  input wire logic so
);
  logic [7:0] rx;

  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    si = 1'b0;
  end

  // One frame of nbits taken from the top of tx; bits past the opcode are read back.
  task automatic xfer(input logic [15:0] tx, input int nbits, input bit idle_hi,
                      input int pause_at);
    rx = 8'h00;
    sck = idle_hi;
    #40 cs_n = 1'b0;
    #62.5;
    for (int i = 0; i < nbits; i++) begin
      sck = 1'b0;
      si = tx[15 - i];
      // A pause with the clock parked low; the device must simply wait.
      if (i == pause_at) #1000;
      #62.5 sck = 1'b1;
      if (i >= 8) rx = {rx[6:0], so};
      #62.5;
    end
    sck = idle_hi;
    #62.5 cs_n = 1'b1;
    // A released data line must not keep its last level.
    si = ~si;
    #1000;
  endtask
endmodule

// File: sim/sws_supervisor_tb.sv
`timescale 1ns/10ps

module sws_supervisor_tb;
  logic core_clk, rst_n, sck, cs_n, si, so, so_oe;
  logic write_guard_n, supply_low, reset_level, reset_oe;
  int num_errors, compares, n;

  sws_supervisor #(.TICK_CYCLES(4), .NV_WRITE_CYCLES(20), .RESET_ACTIVE_HIGH(1'b0))
    sws_supervisor_inst (.core_clk(core_clk), .rst_n(rst_n), .sck(sck), .cs_n(cs_n),
    .si(si), .so(so), .so_oe(so_oe), .write_guard_n(write_guard_n),
    .supply_low(supply_low), .reset_level(reset_level), .reset_oe(reset_oe));

  sws_master_model sws_master_model_inst (.sck(sck), .cs_n(cs_n), .si(si), .so(so));

  // Core clock at 10 MHz.
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  task automatic end_of_test();
    $display("compares %0d num_errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %0t status %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %0t flag %b expected %b", $time, got, exp);
    end
  endtask

  // Inputs of the core domain change at the falling edge only.
  task automatic cyc(input int k);
    repeat (k) @(negedge core_clk);
  endtask

  // Counts cycles until the reset enable reaches v; a hang ends the run.
  task automatic wait_oe(input logic v, input int lim, output int cnt);
    cnt = 0;
    while (reset_oe !== v) begin
      cyc(1);
      cnt++;
      if (cnt > lim) begin
        num_errors++;
        $display("BAD %0t reset enable stuck", $time);
        end_of_test();
      end
    end
  endtask

  // Every frame must leave the output stage released once deselected.
  task automatic frame(input logic [15:0] tx, input int nbits, input bit hi, input int p);
    sws_master_model_inst.xfer(tx, nbits, hi, p);
    chk_bit(so_oe, 1'b0);
  endtask

  task automatic op(input logic [7:0] code);
    frame({code, 8'h00}, 8, 1'b0, -1);
  endtask

  task automatic wr(input logic [7:0] d);
    frame({8'h01, d}, 16, 1'b0, -1);
  endtask

  task automatic rd(input logic [7:0] exp, input bit hi, input int p);
    frame({8'h05, 8'h00}, 16, hi, p);
    chk_byte(sws_master_model_inst.rx, exp);
  endtask

  task automatic t_powerup();
    chk_bit(reset_oe, 1'b1);
    chk_bit(reset_level, 1'b0);
    wait_oe(1'b0, 1000, n);
    chk_bit(n >= 700, 1'b1);
    // The first frame arms the link and is acted on as a status read, but its result is not judged.
    sws_master_model_inst.xfer({8'h05, 8'h00}, 16, 1'b0, -1);
    $display("test powerup done");
  endtask

  task automatic t_latch();
    rd(8'h00, 1'b0, -1);
    op(8'h06);
    rd(8'h02, 1'b1, -1);
    op(8'h04);
    rd(8'h00, 1'b1, 3);
    frame({8'h06, 8'h00}, 9, 1'b0, -1);
    rd(8'h00, 1'b0, -1);
    frame({8'h00, 8'h00}, 8, 1'b1, -1);
    rd(8'h40, 1'b0, -1);
    op(8'h04);
    rd(8'h00, 1'b0, -1);
    $display("test latch done");
  endtask

  task automatic t_write();
    wr(8'hbf);
    rd(8'h00, 1'b0, -1);
    op(8'h06);
    wr(8'hbf);
    rd(8'h03, 1'b0, -1);
    cyc(30);
    rd(8'hbc, 1'b0, -1);
    $display("test write done");
  endtask

  task automatic t_guard();
    cyc(1);
    write_guard_n = 1'b0;
    op(8'h06);
    wr(8'h3c);
    cyc(30);
    rd(8'hbe, 1'b0, -1);
    cyc(1);
    write_guard_n = 1'b1;
    wr(8'h3c);
    cyc(1);
    write_guard_n = 1'b0;
    cyc(30);
    rd(8'h3c, 1'b0, -1);
    op(8'h06);
    wr(8'h2c);
    cyc(30);
    rd(8'h2c, 1'b0, -1);
    cyc(1);
    write_guard_n = 1'b1;
    $display("test guard done");
  endtask

  task automatic t_wdog();
    for (int i = 0; i < 5; i++) begin
      cyc(400);
      rd(8'h2c, 1'b0, -1);
      chk_bit(reset_oe, 1'b0);
    end
    wait_oe(1'b1, 1000, n);
    chk_bit(n >= 700 && n <= 850, 1'b1);
    chk_bit(reset_level, 1'b0);
    wait_oe(1'b0, 1000, n);
    chk_bit(n >= 700, 1'b1);
    op(8'h06);
    wr(8'h3c);
    cyc(30);
    rd(8'h3c, 1'b0, -1);
    $display("test watchdog done");
  endtask

  task automatic t_supply();
    cyc(1);
    supply_low = 1'b1;
    wait_oe(1'b1, 5, n);
    chk_bit(reset_level, 1'b0);
    cyc(100);
    supply_low = 1'b0;
    wait_oe(1'b0, 1000, n);
    chk_bit(n >= 700, 1'b1);
    $display("test supply done");
  endtask

  // Main sequence: reset held for four cycles, then every scenario in turn.
  initial begin
    num_errors = 0;
    compares = 0;
    rst_n = 1'b0;
    write_guard_n = 1'b1;
    supply_low = 1'b0;
    cyc(4);
    rst_n = 1'b1;
    t_powerup();
    t_latch();
    t_write();
    t_guard();
    t_wdog();
    t_supply();
    end_of_test();
  end
endmodule
